// ---- ccsr_consts.svh ----
`ifndef CCSR_CONSTS_SVH
`define CCSR_CONSTS_SVH

// Register byte addresses on the serial port.
`define CCSR_ADDR_CONFIG_A  15'h000
`define CCSR_ADDR_USER_CFG  15'h010
`define CCSR_ADDR_CLK_A     15'h029
`define CCSR_ADDR_CLK_B     15'h02A
`define CCSR_ADDR_POS_HI    15'h02C
`define CCSR_ADDR_POS_MID   15'h02D
`define CCSR_ADDR_POS_LO    15'h02E
`define CCSR_ADDR_FS_A_HI   15'h030
`define CCSR_ADDR_FS_A_LO   15'h031
`define CCSR_ADDR_FS_B_HI   15'h032
`define CCSR_ADDR_FS_B_LO   15'h033
`define CCSR_ADDR_BYPASS    15'h038
`define CCSR_ADDR_TSTAMP    15'h03B

// Field positions.
`define CCSR_BIT_DIR_UP     5
`define CCSR_BIT_FOUR_WIRE  4
`define CCSR_BIT_FREEZE     0
`define CCSR_BIT_PROC_ON    6
`define CCSR_BIT_RECV_ON    5
`define CCSR_BIT_FINE       4
`define CCSR_PICK_MSB       3
`define CCSR_PICK_LSB       0
`define CCSR_BIT_FLIP       0
`define CCSR_BIT_SREF_PECL  1
`define CCSR_BIT_SCLK_PECL  2

// Reset values.
`define CCSR_RST_BYTE       8'h00
`define CCSR_RST_CLK_B      8'h20
`define CCSR_RST_FS         16'hA000
`define CCSR_RST_POS        24'h000000
`define CCSR_RST_TAPS       16'h0000

// Serial frame counts: header is sixteen bits, data comes in bytes.
`define CCSR_HDR_LAST       4'hF
`define CCSR_BYTE_LAST      4'h7
`define CCSR_CNT_ZERO       4'h0
`define CCSR_CNT_ONE        4'h1

`endif

// ---- ccsr_host.sv ----
`default_nettype none

module ccsr_host (
  // Clock.
  input  wire logic clk,
  // Serial pins toward the device.
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half period of sclk, kept above the four-cycle minimum.
  localparam int H = 8;

  // Idle pins at time zero.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // One frame: sixteen header bits, then n bytes, MSB first, mode 0.
  task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                      inout logic [7:0] d [12]);
    logic [15:0] h;
    h = {rd, a};
    cs_n <= 1'b0;
    repeat (H) @(posedge clk);
    for (int k = 0; k < 16 + 8 * n; k++) begin
      if (k < 16) sdi <= h[15 - k];
      else if (!rd) sdi <= d[(k - 16) / 8][7 - (k - 16) % 8];
      else sdi <= ~sdi; // Unused while reading, so it keeps moving.
      repeat (H) @(posedge clk);
      if (rd && k >= 16) d[(k - 16) / 8][7 - (k - 16) % 8] = sdo;
      sclk <= 1'b1;
      repeat (H) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (H) @(posedge clk);
    cs_n <= 1'b1;
    sdi  <= ~sdi; // A released line does not keep its last level.
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : ccsr_host

`default_nettype wire

// ---- ccsr_pkg.sv ----
`default_nettype none

package ccsr_pkg;

  // Phase of the serial frame.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HEADER,
    PH_DATA
  } ccsr_phase_e;

  // State of the serial engine.
  typedef struct packed {
    logic [2:0]  meta;
    logic [2:0]  stab;
    logic        sclk_prev;
    ccsr_phase_e phase;
    logic [3:0]  bitcnt;
    logic [15:0] shin;
    logic [7:0]  shout;
    logic        is_read;
    logic        sdo;
    logic        sdo_oe;
    logic        hdr_stb;
    logic        byte_stb;
  } ccsr_spi_s;

  // State of the register bank and SYSREF path.
  typedef struct packed {
    logic [14:0] addr;
    logic        dir_up;
    logic [7:0]  user_cfg;
    logic [7:0]  clk_a;
    logic [7:0]  clk_b;
    logic [15:0] fs_a;
    logic [15:0] fs_b;
    logic [7:0]  bypass;
    logic [7:0]  tstamp;
    logic        sref_m;
    logic        sref_s;
    logic [15:0] taps;
    logic        aligned;
    logic        aligned_prev;
    logic        div;
    logic [23:0] history;
    logic [23:0] edge_pos;
    logic        event_p;
  } ccsr_regs_s;

endpackage : ccsr_pkg

`default_nettype wire

// ---- ccsr_regs.sv ----
`include "ccsr_consts.svh"
`default_nettype none

// Overview of operation
// - Freeze clear: address steps by stream direction.
// - Freeze set: address held through streaming.
// - Direction set increments, clear decrements address.
// - SYSREF events acted on only with processor on.
// - Fine view changes reported edge position.
// - Delay pick selects SYSREF delay tap.
// - Polarity flip inverts SYSREF before alignment.
// - PECL mode bits for sample clock, SYSREF.
// - Edge position is 24-bit, read only.
// - Full-scale words set input ranges.

module ccsr_regs
  import ccsr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Four-wire serial port pins.
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sdi,
  output var  logic        spi_sdo,
  output var  logic        spi_sdo_oe,
  // SYSREF pin, asynchronous.
  input  wire logic        sysref_in,
  // SYSREF path results.
  output var  logic        sysref_aligned,
  output var  logic        sysref_event,
  // Analog front-end controls.
  output var  logic        sysref_receiver_on,
  output var  logic        sysref_pecl_mode,
  output var  logic        sample_clock_pecl_mode,
  output var  logic [15:0] input_a_full_scale,
  output var  logic [15:0] input_b_full_scale,
  output var  logic [7:0]  reference_bypass,
  output var  logic [7:0]  timestamp_input_control
);

  localparam ccsr_regs_s RESET_VAL = '{
    addr:     15'h0000,
    dir_up:   1'b1,
    user_cfg: `CCSR_RST_BYTE,
    clk_a:    `CCSR_RST_BYTE,
    clk_b:    `CCSR_RST_CLK_B,
    fs_a:     `CCSR_RST_FS,
    fs_b:     `CCSR_RST_FS,
    bypass:   `CCSR_RST_BYTE,
    tstamp:   `CCSR_RST_BYTE,
    taps:     `CCSR_RST_TAPS,
    history:  `CCSR_RST_POS,
    edge_pos: `CCSR_RST_POS,
    default:  '0
  };

  ccsr_spi_if bus ();

  ccsr_regs_s  q;
  ccsr_regs_s  d;
  logic        freeze;
  logic        proc_on;
  logic        recv_on;
  logic        fine;
  logic        flip;
  logic [3:0]  pick;
  logic        sref_in;
  logic        hist_en;
  logic        edge_seen;
  logic        wr_en;
  logic [14:0] next_addr;

  // Serial engine: synchronises the pins and decodes the frame.
  ccsr_spi_engine u_engine (
    .clk        (clk),
    .reset      (reset),
    .spi_sclk   (spi_sclk),
    .spi_cs_n   (spi_cs_n),
    .spi_sdi    (spi_sdi),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .bus        (bus.engine)
  );

  // Control fields pulled out of the stored registers.
  assign freeze  = q.user_cfg[`CCSR_BIT_FREEZE];
  assign proc_on = q.clk_a[`CCSR_BIT_PROC_ON];
  assign recv_on = q.clk_a[`CCSR_BIT_RECV_ON];
  assign fine    = q.clk_a[`CCSR_BIT_FINE];
  assign pick    = q.clk_a[`CCSR_PICK_MSB:`CCSR_PICK_LSB];
  assign flip    = q.clk_b[`CCSR_BIT_FLIP];

  // Returns the byte seen at one address; unmapped space reads zero.
  function automatic logic [7:0] read_byte(
    input ccsr_regs_s  r,
    input logic [14:0] a
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `CCSR_ADDR_CONFIG_A: begin
        v[`CCSR_BIT_DIR_UP]    = r.dir_up;
        v[`CCSR_BIT_FOUR_WIRE] = 1'b1;
      end
      `CCSR_ADDR_USER_CFG: v = r.user_cfg;
      `CCSR_ADDR_CLK_A:    v = r.clk_a;
      `CCSR_ADDR_CLK_B:    v = r.clk_b;
      `CCSR_ADDR_POS_HI:   v = r.edge_pos[23:16];
      `CCSR_ADDR_POS_MID:  v = r.edge_pos[15:8];
      `CCSR_ADDR_POS_LO:   v = r.edge_pos[7:0];
      `CCSR_ADDR_FS_A_HI:  v = r.fs_a[15:8];
      `CCSR_ADDR_FS_A_LO:  v = r.fs_a[7:0];
      `CCSR_ADDR_FS_B_HI:  v = r.fs_b[15:8];
      `CCSR_ADDR_FS_B_LO:  v = r.fs_b[7:0];
      `CCSR_ADDR_BYPASS:   v = r.bypass;
      `CCSR_ADDR_TSTAMP:   v = r.tstamp;
      default:             v = 8'h00;
    endcase
    return v;
  endfunction : read_byte

  // Read data follows the current address so it is ready before the
  // next falling clock edge on the serial port.
  assign bus.rdata = read_byte(q, q.addr);

  // A data byte is written only in a write frame.
  assign wr_en = bus.byte_stb & ~bus.is_read;

  // Streaming step: held, counted up or counted down.
  always_comb begin
    if (freeze) begin
      next_addr = q.addr;
    end else if (q.dir_up) begin
      next_addr = q.addr + 15'h0001;
    end else begin
      next_addr = q.addr - 15'h0001;
    end
  end

  // SYSREF after the polarity choice; a disabled receiver reads low.
  assign sref_in = recv_on & (q.sref_s ^ flip);

  // The coarse view samples every other cycle, the fine view every one.
  assign hist_en = fine | q.div;

  // A rising edge on the aligned SYSREF is an event.
  assign edge_seen = q.aligned & ~q.aligned_prev;

  // Next state of the whole bank.
  always_comb begin
    d = q;

    // Address register: loaded by the header, stepped after each byte.
    if (bus.hdr_stb) begin
      d.addr = bus.hdr_addr;
    end else if (bus.byte_stb) begin
      d.addr = next_addr;
    end

    // Register writes; read-only status ignores them.
    if (wr_en) begin
      case (q.addr)
        `CCSR_ADDR_CONFIG_A: begin
          d.dir_up = bus.wdata[`CCSR_BIT_DIR_UP];
        end
        `CCSR_ADDR_USER_CFG: d.user_cfg = bus.wdata;
        `CCSR_ADDR_CLK_A:    d.clk_a = bus.wdata;
        `CCSR_ADDR_CLK_B:    d.clk_b = bus.wdata;
        `CCSR_ADDR_FS_A_HI:  d.fs_a[15:8] = bus.wdata;
        `CCSR_ADDR_FS_A_LO:  d.fs_a[7:0] = bus.wdata;
        `CCSR_ADDR_FS_B_HI:  d.fs_b[15:8] = bus.wdata;
        `CCSR_ADDR_FS_B_LO:  d.fs_b[7:0] = bus.wdata;
        `CCSR_ADDR_BYPASS:   d.bypass = bus.wdata;
        `CCSR_ADDR_TSTAMP:   d.tstamp = bus.wdata;
        default: begin
          d.addr = d.addr;
        end
      endcase
    end

    // SYSREF pin synchroniser; only the second stage is used.
    d.sref_m = sysref_in;
    d.sref_s = q.sref_m;

    // Delay line; the chosen tap becomes the aligned SYSREF.
    d.taps         = {q.taps[14:0], sref_in};
    d.aligned      = q.taps[pick];
    d.aligned_prev = q.aligned;

    // Coarse sampling divider.
    d.div = ~q.div;

    // Edge history and capture, both gated by the processor enable.
    d.event_p = 1'b0;
    if (proc_on) begin
      if (hist_en) begin
        d.history = {q.history[22:0], sref_in};
      end
      if (edge_seen) begin
        d.event_p  = 1'b1;
        d.edge_pos = q.history;
      end
    end
  end

  // State register; the control bank takes its reset values here.
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign sysref_aligned          = q.aligned;
  assign sysref_event            = q.event_p;
  assign sysref_receiver_on      = recv_on;
  assign sysref_pecl_mode        = q.clk_b[`CCSR_BIT_SREF_PECL];
  assign sample_clock_pecl_mode  = q.clk_b[`CCSR_BIT_SCLK_PECL];
  assign input_a_full_scale      = q.fs_a;
  assign input_b_full_scale      = q.fs_b;
  assign reference_bypass        = q.bypass;
  assign timestamp_input_control = q.tstamp;

endmodule : ccsr_regs

`default_nettype wire

// ---- ccsr_regs_monitor.sv ----
`default_nettype none

module ccsr_regs_monitor (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset,
  // Serial port pins.
  input wire logic        spi_cs_n,
  input wire logic        spi_sdo_oe,
  // SYSREF path and analog controls.
  input wire logic        sysref_aligned,
  input wire logic        sysref_event,
  input wire logic        sysref_receiver_on,
  input wire logic        sysref_pecl_mode,
  input wire logic        sample_clock_pecl_mode,
  input wire logic [15:0] input_a_full_scale,
  input wire logic [15:0] input_b_full_scale
);
  logic [4:0] off_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Counts cycles since the receiver was switched off.
  always_ff @(posedge clk) begin
    if (reset || sysref_receiver_on) off_q <= 5'h00;
    else if (off_q != 5'h1F) off_q <= off_q + 5'h01;
  end

  fs_reset_a: assert property (
    $fell(reset) |-> input_a_full_scale == 16'hA000
      && input_b_full_scale == 16'hA000)
    else $error("full-scale words not at reset value");
  sref_reset_a: assert property (
    $fell(reset) |-> !sysref_event && !sysref_aligned && !spi_sdo_oe)
    else $error("SYSREF or sdo enable active after reset");
  event_pulse_a: assert property (
    sysref_event |=> !sysref_event)
    else $error("SYSREF event longer than one cycle");
  event_cause_a: assert property (
    sysref_event |-> $past(sysref_aligned) && !$past(sysref_aligned, 2))
    else $error("SYSREF event without aligned rising edge");
  recv_gate_a: assert property (
    off_q >= 5'h18 |-> !sysref_aligned)
    else $error("aligned SYSREF high with receiver off");
  sdo_release_a: assert property (
    spi_cs_n [*6] |-> !spi_sdo_oe)
    else $error("sdo driven with chip select high");
  fs_write_a: assert property (
    !$past(reset) && $changed({input_a_full_scale, input_b_full_scale})
      |-> !$past(spi_cs_n, 4))
    else $error("full-scale word changed outside a frame");
  mode_write_a: assert property (
    !$past(reset) && $changed({sysref_receiver_on, sysref_pecl_mode,
      sample_clock_pecl_mode}) |-> !$past(spi_cs_n, 4))
    else $error("clock control changed outside a frame");
endmodule : ccsr_regs_monitor

bind ccsr_regs ccsr_regs_monitor ccsr_regs_monitor_inst (
  .clk(clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .sysref_aligned(sysref_aligned), .sysref_event(sysref_event),
  .sysref_receiver_on(sysref_receiver_on),
  .sysref_pecl_mode(sysref_pecl_mode),
  .sample_clock_pecl_mode(sample_clock_pecl_mode),
  .input_a_full_scale(input_a_full_scale),
  .input_b_full_scale(input_b_full_scale));

`default_nettype wire

// ---- ccsr_spi_engine.sv ----
`include "ccsr_consts.svh"
`default_nettype none

module ccsr_spi_engine
  import ccsr_pkg::*;
(
  // Clock and reset.
  input  wire logic   clk,
  input  wire logic   reset,
  // Serial pins, raw from outside.
  input  wire logic   spi_sclk,
  input  wire logic   spi_cs_n,
  input  wire logic   spi_sdi,
  output var  logic   spi_sdo,
  output var  logic   spi_sdo_oe,
  // Frame events toward the registers.
  ccsr_spi_if.engine  bus
);

  // Chip select rests high in the synchroniser, so that no false frame
  // start is seen in the cycles right after reset.
  localparam ccsr_spi_s RESET_VAL = '{
    meta:    3'h2,
    stab:    3'h2,
    phase:   PH_IDLE,
    bitcnt:  `CCSR_CNT_ZERO,
    default: '0
  };

  ccsr_spi_s q;
  ccsr_spi_s d;
  logic      sclk_s;
  logic      cs_n_s;
  logic      sdi_s;
  logic      rise;
  logic      fall;

  // Only the second synchroniser stage is looked at.
  assign sclk_s = q.stab[2];
  assign cs_n_s = q.stab[1];
  assign sdi_s  = q.stab[0];
  assign rise   = sclk_s & ~q.sclk_prev;
  assign fall   = ~sclk_s & q.sclk_prev;

  // Frame decoder: header bits on rising edges, read data on falling ones.
  always_comb begin
    d          = q;
    d.meta     = {spi_sclk, spi_cs_n, spi_sdi};
    d.stab     = q.meta;
    d.sclk_prev = sclk_s;
    d.hdr_stb  = 1'b0;
    d.byte_stb = 1'b0;
    if (cs_n_s) begin
      d.phase  = PH_IDLE;
      d.bitcnt = `CCSR_CNT_ZERO;
      d.sdo_oe = 1'b0;
      d.sdo    = 1'b0;
    end else begin
      case (q.phase)
        PH_IDLE: begin
          d.phase  = PH_HEADER;
          d.bitcnt = `CCSR_CNT_ZERO;
        end
        PH_HEADER: begin
          if (rise) begin
            d.shin   = {q.shin[14:0], sdi_s};
            d.bitcnt = q.bitcnt + `CCSR_CNT_ONE;
            if (q.bitcnt == `CCSR_HDR_LAST) begin
              d.hdr_stb = 1'b1;
              d.is_read = q.shin[14];
              d.phase   = PH_DATA;
              d.bitcnt  = `CCSR_CNT_ZERO;
            end
          end
        end
        PH_DATA: begin
          if (rise) begin
            d.shin   = {q.shin[14:0], sdi_s};
            d.bitcnt = q.bitcnt + `CCSR_CNT_ONE;
            if (q.bitcnt == `CCSR_BYTE_LAST) begin
              d.byte_stb = 1'b1;
              d.bitcnt   = `CCSR_CNT_ZERO;
            end
          end
          // A falling edge at count zero starts the next read byte.
          if (fall && q.is_read) begin
            d.sdo_oe = 1'b1;
            if (q.bitcnt == `CCSR_CNT_ZERO) begin
              d.sdo   = bus.rdata[7];
              d.shout = {bus.rdata[6:0], 1'b0};
            end else begin
              d.sdo   = q.shout[7];
              d.shout = {q.shout[6:0], 1'b0};
            end
          end
        end
        default: begin
          d.phase = PH_IDLE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  // Frame events and pin drive.
  assign bus.hdr_stb  = q.hdr_stb;
  assign bus.byte_stb = q.byte_stb;
  assign bus.is_read  = q.is_read;
  assign bus.hdr_addr = q.shin[14:0];
  assign bus.wdata    = q.shin[7:0];
  assign spi_sdo      = q.sdo;
  assign spi_sdo_oe   = q.sdo_oe;

endmodule : ccsr_spi_engine

`default_nettype wire

// ---- ccsr_spi_if.sv ----
`default_nettype none

// Carries decoded frame events from the serial engine to the registers.
interface ccsr_spi_if;
  logic        hdr_stb;
  logic        byte_stb;
  logic        is_read;
  logic [14:0] hdr_addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  modport engine (
    output hdr_stb, byte_stb, is_read, hdr_addr, wdata,
    input  rdata
  );

  modport regs (
    input  hdr_stb, byte_stb, is_read, hdr_addr, wdata,
    output rdata
  );
endinterface : ccsr_spi_if

`default_nettype wire

// ---- tb.sv ----
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, reset, sclk, cs_n, sdi, sdo, sref, algn, evt;
  logic        rcv, spec, cpec;
  logic [15:0] fsa, fsb;
  logic [7:0]  byp, tsc;
  logic [7:0]  d [12];
  logic [7:0]  mdl [int];
  logic [14:0] zr [6] = '{15'h010, 15'h029, 15'h031, 15'h033, 15'h038,
                          15'h03B};
  int          fail_count, samples_checked, n, l, lat [2];

  ccsr_regs ccsr_regs_inst (
    .clk(clk), .reset(reset), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(), .sysref_in(sref),
    .sysref_aligned(algn), .sysref_event(evt), .sysref_receiver_on(rcv),
    .sysref_pecl_mode(spec), .sample_clock_pecl_mode(cpec),
    .input_a_full_scale(fsa), .input_b_full_scale(fsb),
    .reference_bypass(byp), .timestamp_input_control(tsc));

  ccsr_host ccsr_host_inst (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Model write: only bit 5 of the config byte and mapped places store.
  task automatic mw(input logic [14:0] a, input logic [7:0] v);
    if (a == 15'h000) mdl[a] = {2'b00, v[5], 5'h10};
    else if (mdl.exists(a)) mdl[a] = v;
  endtask : mw

  // Model read: unmapped places and the edge status read zero.
  function automatic logic [7:0] rdm(input logic [14:0] a);
    return mdl.exists(a) ? mdl[a] : 8'h00;
  endfunction : rdm

  // Next streaming address after the model's hold and direction bits.
  function automatic logic [14:0] nxt(input logic [14:0] a);
    if (mdl[15'h010][0]) return a;
    return mdl[15'h000][5] ? a + 15'h0001 : a - 15'h0001;
  endfunction : nxt

  // Stream write of n bytes from d, mirrored into the model.
  task automatic sw(input logic [14:0] a, input int n);
    ccsr_host_inst.xfer(1'b0, a, n, d);
    for (int k = 0; k < n; k++) begin
      mw(a, d[k]);
      a = nxt(a);
    end
  endtask : sw

  // Stream read of n bytes, each compared with the model.
  task automatic sr(input logic [14:0] a, input int n);
    ccsr_host_inst.xfer(1'b1, a, n, d);
    for (int k = 0; k < n; k++) begin
      check(d[k], rdm(a));
      a = nxt(a);
    end
  endtask : sr

  // Raises SYSREF for 80 cycles, counting late cycles and events.
  task automatic sp(output int l, output int e);
    l = 0;
    e = 0;
    sref <= 1'b1;
    for (int k = 0; k < 80; k++) begin
      @(posedge clk);
      if (algn !== 1'b1) l++;
      if (evt === 1'b1) e++;
    end
    sref <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : sp

  // Writes one byte.
  task automatic w1(input logic [14:0] a, input logic [7:0] v);
    d[0] = v;
    sw(a, 1);
  endtask : w1

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Main sequence.
  initial begin
    reset = 1'b1;
    sref = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    mdl[15'h000] = 8'h30;
    mdl[15'h02A] = 8'h20;
    mdl[15'h030] = 8'hA0;
    mdl[15'h032] = 8'hA0;
    foreach (zr[i]) mdl[zr[i]] = 8'h00;
    void'($urandom(83));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    sr(15'h029, 11);
    sr(15'h000, 1);
    sr(15'h010, 1);
    check(fsa, 16'hA000);
    $display("test reset values finished");
    for (int k = 0; k < 4; k++) d[k] = 8'($urandom) | 8'h20;
    sw(15'h030, 4);
    check(fsa, {mdl[15'h030], mdl[15'h031]});
    check(fsb, {mdl[15'h032], mdl[15'h033]});
    for (int k = 0; k < 3; k++) d[k] = 8'($urandom);
    sw(15'h02C, 3);
    sr(15'h02C, 8);
    $display("test ascending stream finished");
    w1(15'h000, 8'h00);
    d[0] = 8'($urandom);
    d[1] = 8'($urandom) | 8'h20;
    sw(15'h031, 2);
    sr(15'h033, 4);
    w1(15'h000, 8'h20);
    $display("test descending stream finished");
    w1(15'h010, 8'h01);
    for (int k = 0; k < 3; k++) d[k] = 8'($urandom);
    sw(15'h038, 3);
    check(byp, mdl[15'h038]);
    sr(15'h038, 2);
    d[0] = 8'($urandom);
    d[1] = 8'($urandom);
    sw(15'h03B, 2);
    check(tsc, mdl[15'h03B]);
    w1(15'h010, 8'h00);
    $display("test address hold finished");
    w1(15'h02A, {5'b00100, 3'($urandom)});
    check({cpec, spec}, mdl[15'h02A][2:1]);
    w1(15'h02A, 8'h20);
    $display("test clock modes finished");
    w1(15'h029, 8'h20);
    check(rcv, 1'b1);
    sp(l, n);
    check(16'(n), 16'h0000);
    w1(15'h029, 8'h60);
    sp(lat[0], n);
    check(16'(n), 16'h0001);
    ccsr_host_inst.xfer(1'b1, 15'h02C, 3, d);
    check({d[0], d[1]}, 16'h0000);
    check({8'h00, d[2]}, 16'h0001);
    w1(15'h029, 8'h70);
    sp(l, n);
    ccsr_host_inst.xfer(1'b1, 15'h02C, 3, d);
    check({d[1], d[2]}, 16'h0003);
    w1(15'h029, 8'h63);
    sp(lat[1], n);
    check(16'(lat[1] - lat[0]), 16'h0003);
    w1(15'h029, 8'h60);
    w1(15'h02A, 8'h21);
    sp(l, n);
    check(algn, 1'b1);
    check(16'(n), 16'h0000);
    check(16'(l + lat[0]), 16'h0050);
    w1(15'h02A, 8'h20);
    $display("test sysref path finished");
    wrap_up();
  end
endmodule : tb

`default_nettype wire
